// [core/rmbc_consts.svh]
/*
 * timing, rate and coder constants shared by the baseband coder's two ends.
 * assumes a single 20 MHz core clock feeding both ends.
 */
`ifndef RMBC_CONSTS_SVH
`define RMBC_CONSTS_SVH

// ----------------------------------------
// clock and line rates
// ----------------------------------------
`define RMBC_CLK_HZ 20000000
`define RMBC_RATE_LO_BPS 4800
`define RMBC_RATE_MID_BPS 9600
`define RMBC_RATE_HI_BPS 19200
`define RMBC_OVS 16
`define RMBC_OVS_W 4
`define RMBC_DIV_W 16
// sample point of a bit cell, counted from the last line transition
`define RMBC_RX_SAMPLE_PHASE 4'h7
`define RMBC_OVS_LAST 4'hf

// ----------------------------------------
// scrambler
// ----------------------------------------
`define RMBC_SCR_LEN 7
`define RMBC_SCR_TAP_A 6
`define RMBC_SCR_TAP_B 3
`define RMBC_SCR_RESET 7'h00

// ----------------------------------------
// serial framing on the host side
// ----------------------------------------
`define RMBC_BYTE_BITS 8
`define RMBC_BITCNT_LAST 3'h7
`define RMBC_IDLE_BIT 1'b1

`endif

// [core/rmbc_pkg.sv]
/*
 * types and shared functions of the baseband coder.
 * assumes rmbc_consts.svh is on the include path.
 */
`include "rmbc_consts.svh"

package rmbc_pkg;

	// line rate select; the spare code runs at the highest rate
	typedef enum logic [1:0] {
		RMBC_RATE_4800 = 2'h0,
		RMBC_RATE_9600 = 2'h1,
		RMBC_RATE_19200 = 2'h2,
		RMBC_RATE_SPARE = 2'h3
	} rmbc_rate_t;

	// host transmit serialiser states
	typedef enum logic [1:0] {
		RMBC_TX_IDLE = 2'h1,
		RMBC_TX_SHIFT = 2'h2
	} rmbc_htx_state_t;

	// oversampling divisor for a rate, rounded down
	function automatic logic [`RMBC_DIV_W-1:0] rmbc_ovs_div(input rmbc_rate_t rate);
		int bps;
		bps = `RMBC_RATE_HI_BPS;
		unique case (rate)
			RMBC_RATE_4800: bps = `RMBC_RATE_LO_BPS;
			RMBC_RATE_9600: bps = `RMBC_RATE_MID_BPS;
			RMBC_RATE_19200, RMBC_RATE_SPARE: bps = `RMBC_RATE_HI_BPS;
		endcase
		return `RMBC_DIV_W'(`RMBC_CLK_HZ / (bps * `RMBC_OVS));
	endfunction : rmbc_ovs_div

	// feedback of the seven-stage scrambler register
	function automatic logic rmbc_scr_fb(input logic [`RMBC_SCR_LEN-1:0] sr);
		return sr[`RMBC_SCR_TAP_A] ^ sr[`RMBC_SCR_TAP_B];
	endfunction : rmbc_scr_fb

endpackage : rmbc_pkg

// [core/rmbc_link_if.sv]
/*
 * synchronous serial channel between host and baseband coder.
 * assumes both ends run on the same core clock; strobes are one cycle wide.
 */
`timescale 1ns/1ps

interface rmbc_link_if;
	import rmbc_pkg::*;

	rmbc_rate_t rate_sel; // host: selected line rate
	logic tx_en; // host: transmit direction select
	logic tx_bit; // host: current outgoing bit
	logic tx_bit_req; // modem: pulse, tx_bit taken, present the next
	logic rx_bit; // modem: received, descrambled bit
	logic rx_bit_stb; // modem: pulse, rx_bit valid

	modport modem (
		input rate_sel,
		input tx_en,
		input tx_bit,
		output tx_bit_req,
		output rx_bit,
		output rx_bit_stb
	);

	modport host (
		output rate_sel,
		output tx_en,
		output tx_bit,
		input tx_bit_req,
		input rx_bit,
		input rx_bit_stb
	);
endinterface : rmbc_link_if

// [core/rmbc_modem_end.sv]
/*
 * baseband coder, modem end: scrambles, nrzi-encodes and synthesises the
 * transmit baseband level; synchronises, recovers clock, decodes and descrambles
 * on receive; steers the shared filter and programs its cut-off.
 * assumes the host end on the link, the same core clock on both ends, and
 * an asynchronous sliced receive level on rx_baseband_in_i.
 */
// Functional notes
// - three line rates, 4800, 9600, 19200 bps
// - transmit bits pass a 7-bit scrambler
// - nrzi encode transmit, nrzi decode receive
// - host sends sync bits, modem makes baseband
// - filter cut-off follows selected data rate
// - one filter, steered by transmit select
// - receive: recover bit clock, then descramble
// - descrambled bits go synchronously to host
// - host clock from crystal divided by two
// - host supplies the modem's only clock
`timescale 1ns/1ps

module rmbc_modem_end
	import rmbc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	rmbc_link_if.modem link,
	input wire logic rx_baseband_in_i,
	output logic tx_baseband_out_o,
	output logic [1:0] filter_cutoff_o,
	output logic filter_tx_path_o,
	output logic filter_rx_path_o
);

	// ----------------------------------------
	// oversampling divider
	// ----------------------------------------
	logic [`RMBC_DIV_W-1:0] div_cnt_r;
	logic [`RMBC_DIV_W-1:0] div_cnt_nxt;
	logic [`RMBC_DIV_W-1:0] div_last;
	logic ovs_tick;

	// divisor picked from the live rate; a change applies to the period in progress, which ends at once if already past the new last count
	assign div_last = rmbc_ovs_div(link.rate_sel) - `RMBC_DIV_W'h1;
	assign ovs_tick = (div_cnt_r >= div_last);
	assign div_cnt_nxt = ovs_tick ? '0 : div_cnt_r + `RMBC_DIV_W'h1;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			div_cnt_r <= '0;
		end else begin
			div_cnt_r <= div_cnt_nxt;
		end
	end

	// ----------------------------------------
	// filter control
	// ----------------------------------------
	logic [1:0] cutoff_r;
	logic tx_path_r;
	logic rx_path_r;

	// the two path gates are exclusive so the filter never loops on itself
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			cutoff_r <= RMBC_RATE_4800;
			tx_path_r <= 1'b0;
			rx_path_r <= 1'b1;
		end else begin
			cutoff_r <= link.rate_sel;
			tx_path_r <= link.tx_en;
			rx_path_r <= ~link.tx_en;
		end
	end

	assign filter_cutoff_o = cutoff_r;
	assign filter_tx_path_o = tx_path_r;
	assign filter_rx_path_o = rx_path_r;

	// ----------------------------------------
	// transmit: bit timing
	// ----------------------------------------
	logic [`RMBC_OVS_W-1:0] tx_phase_r;
	logic tx_bit_tick;
	logic tx_req_r;

	assign tx_bit_tick = ovs_tick && (tx_phase_r == `RMBC_OVS_LAST);

	// a request pulse per bit cell; the host holds tx_bit until it sees it
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			tx_phase_r <= '0;
			tx_req_r <= 1'b0;
		end else begin
			if (ovs_tick) begin
				tx_phase_r <= tx_phase_r + `RMBC_OVS_W'h1;
			end
			tx_req_r <= tx_bit_tick && link.tx_en;
		end
	end

	assign link.tx_bit_req = tx_req_r;

	// ----------------------------------------
	// transmit: scrambler and nrzi encoder
	// ----------------------------------------
	logic [`RMBC_SCR_LEN-1:0] tx_sr_r;
	logic tx_scr_bit;
	logic tx_level_r;
	logic tx_level_nxt;

	assign tx_scr_bit = link.tx_bit ^ rmbc_scr_fb(tx_sr_r);
	// zero toggles, one holds
	assign tx_level_nxt = tx_scr_bit ? tx_level_r : ~tx_level_r;

	// the scrambled bit feeds back, so the far end locks after seven bits
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			tx_sr_r <= `RMBC_SCR_RESET;
			tx_level_r <= 1'b0;
		end else if (tx_req_r) begin
			tx_sr_r <= {tx_sr_r[`RMBC_SCR_LEN-2:0], tx_scr_bit};
			tx_level_r <= tx_level_nxt;
		end
	end

	// constant-amplitude baseband: a two-level line signal, shaped by the filter
	assign tx_baseband_out_o = tx_level_r;

	// ----------------------------------------
	// receive: slicer input synchroniser
	// ----------------------------------------
	logic rx_meta_r;
	logic rx_sync_r;
	logic rx_last_r;
	logic rx_edge;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rx_meta_r <= 1'b0;
			rx_sync_r <= 1'b0;
			rx_last_r <= 1'b0;
		end else begin
			rx_meta_r <= rx_baseband_in_i;
			rx_sync_r <= rx_meta_r;
			rx_last_r <= rx_sync_r;
		end
	end

	assign rx_edge = rx_sync_r ^ rx_last_r;

	// ----------------------------------------
	// receive: clock recovery
	// ----------------------------------------
	logic [`RMBC_OVS_W-1:0] rx_phase_r;
	logic rx_sample;

	// sample mid-cell; long runs free-wheel on the local divider
	assign rx_sample = ovs_tick && (rx_phase_r == `RMBC_RX_SAMPLE_PHASE) && !link.tx_en;

	// every transition realigns the cell so drift never accumulates
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rx_phase_r <= '0;
		end else if (rx_edge) begin
			rx_phase_r <= '0;
		end else if (ovs_tick) begin
			rx_phase_r <= rx_phase_r + `RMBC_OVS_W'h1;
		end
	end

	// ----------------------------------------
	// receive: nrzi decoder and descrambler
	// ----------------------------------------
	logic rx_prev_level_r;
	logic rx_dec_bit;
	logic [`RMBC_SCR_LEN-1:0] rx_sr_r;
	logic rx_bit_r;
	logic rx_stb_r;

	assign rx_dec_bit = (rx_sync_r == rx_prev_level_r);

	// exact inverse of the scrambler: same taps, fed with line bits
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rx_prev_level_r <= 1'b0;
			rx_sr_r <= `RMBC_SCR_RESET;
			rx_bit_r <= 1'b0;
			rx_stb_r <= 1'b0;
		end else begin
			rx_stb_r <= rx_sample;
			if (rx_sample) begin
				rx_prev_level_r <= rx_sync_r;
				rx_sr_r <= {rx_sr_r[`RMBC_SCR_LEN-2:0], rx_dec_bit};
				rx_bit_r <= rx_dec_bit ^ rmbc_scr_fb(rx_sr_r);
			end
		end
	end

	assign link.rx_bit = rx_bit_r;
	assign link.rx_bit_stb = rx_stb_r;

endmodule : rmbc_modem_end

// [core/rmbc_host_end.sv]
/*
 * baseband coder, host end: serialises bytes onto the synchronous channel,
 * collects received bits into bytes, and drives rate and direction.
 * assumes the modem end on the link and the same core clock; the host's
 * async conversion and byte framing live above this module.
 */
`timescale 1ns/1ps

module rmbc_host_end
	import rmbc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	rmbc_link_if.host link,
	input wire logic [1:0] rate_sel_i,
	input wire logic tx_en_i,
	input wire logic [7:0] tx_byte_i,
	input wire logic tx_byte_valid_i,
	output logic tx_byte_ready_o,
	output logic [7:0] rx_byte_o,
	output logic rx_byte_valid_o
);

	// ----------------------------------------
	// rate and direction
	// ----------------------------------------
	rmbc_rate_t rate_r;
	logic tx_en_r;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rate_r <= RMBC_RATE_4800;
			tx_en_r <= 1'b0;
		end else begin
			rate_r <= rmbc_rate_t'(rate_sel_i);
			tx_en_r <= tx_en_i;
		end
	end

	assign link.rate_sel = rate_r;
	assign link.tx_en = tx_en_r;

	// ----------------------------------------
	// transmit serialiser, lsb first
	// ----------------------------------------
	rmbc_htx_state_t tx_state_r;
	logic [7:0] tx_sh_r;
	logic [2:0] tx_cnt_r;
	logic tx_ready_r;
	logic load;
	logic last_bit;

	assign load = tx_byte_valid_i && tx_ready_r;
	assign last_bit = link.tx_bit_req && (tx_cnt_r == `RMBC_BITCNT_LAST);

	// ready is a flop: one byte is accepted, then ready drops until it is sent
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			tx_state_r <= RMBC_TX_IDLE;
			tx_sh_r <= '0;
			tx_cnt_r <= '0;
			tx_ready_r <= 1'b0;
		end else begin
			unique case (tx_state_r)
				RMBC_TX_IDLE: begin
					tx_ready_r <= ~load;
					if (load) begin
						tx_sh_r <= tx_byte_i;
						tx_cnt_r <= '0;
						tx_state_r <= RMBC_TX_SHIFT;
					end
				end
				RMBC_TX_SHIFT: begin
					if (link.tx_bit_req) begin
						tx_sh_r <= {1'b0, tx_sh_r[7:1]};
						tx_cnt_r <= tx_cnt_r + 3'h1;
					end
					if (last_bit) begin
						tx_state_r <= RMBC_TX_IDLE;
						tx_ready_r <= 1'b1;
					end
				end
			endcase
		end
	end

	// idle marks between bytes keep the line busy without data
	assign link.tx_bit = (tx_state_r == RMBC_TX_SHIFT) ? tx_sh_r[0] : `RMBC_IDLE_BIT;
	assign tx_byte_ready_o = tx_ready_r;

	// ----------------------------------------
	// receive deserialiser, lsb first
	// ----------------------------------------
	logic [7:0] rx_sh_r;
	logic [2:0] rx_cnt_r;
	logic [7:0] rx_byte_r;
	logic rx_valid_r;
	logic [7:0] rx_sh_nxt;

	assign rx_sh_nxt = {link.rx_bit, rx_sh_r[7:1]};

	// no byte alignment here: framing is the upper layer's job
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rx_sh_r <= '0;
			rx_cnt_r <= '0;
			rx_byte_r <= '0;
			rx_valid_r <= 1'b0;
		end else begin
			rx_valid_r <= 1'b0;
			if (link.rx_bit_stb) begin
				rx_sh_r <= rx_sh_nxt;
				rx_cnt_r <= rx_cnt_r + 3'h1;
				if (rx_cnt_r == `RMBC_BITCNT_LAST) begin
					rx_byte_r <= rx_sh_nxt;
					rx_valid_r <= 1'b1;
				end
			end
		end
	end

	assign rx_byte_o = rx_byte_r;
	assign rx_byte_valid_o = rx_valid_r;

endmodule : rmbc_host_end

// [tb/rmbc_link_properties.sv]
/*
 * concurrent checks on the host-modem link and the modem's filter and line pins.
 * assumes one core clock and a synchronous active-low reset on both ends.
 */
`timescale 1ns/1ps

module rmbc_link_properties
	import rmbc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input rmbc_rate_t rate_sel,
	input logic tx_en,
	input logic tx_bit_req,
	input logic rx_bit,
	input logic rx_bit_stb,
	input logic tx_baseband_out_o,
	input logic [1:0] filter_cutoff_o,
	input logic filter_tx_path_o,
	input logic filter_rx_path_o
);
	// slowest cell of 4160 clocks plus 140 clocks of slack after a rate change
	localparam int IDLE_MAX = 4300;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	// cycles spent transmitting without a bit request
	logic [12:0] idle_cnt;
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i || !tx_en || tx_bit_req) begin
			idle_cnt <= 13'h0;
		end else begin
			idle_cnt <= idle_cnt + 13'h1;
		end
	end

	AST_REQ_BOUND: assert property (idle_cnt < IDLE_MAX)
		else $error("bit request overdue");
	AST_REQ_OFF: assert property (!tx_en && !$past(tx_en) |-> !tx_bit_req)
		else $error("bit request while not transmitting");
	AST_REQ_PULSE: assert property (tx_bit_req |=> (!tx_bit_req) [*8])
		else $error("bit request too wide or too close");
	AST_LINE_HOLD: assert property (!tx_bit_req |=> $stable(tx_baseband_out_o))
		else $error("line level moved without a bit request");
	AST_CUTOFF: assert property (filter_cutoff_o == 2'($past(rate_sel)))
		else $error("filter cut-off does not follow rate");
	AST_PATH: assert property (filter_tx_path_o == $past(tx_en) &&
		filter_rx_path_o == !$past(tx_en))
		else $error("filter steering wrong");
	AST_STB_OFF: assert property (tx_en && $past(tx_en) |-> !rx_bit_stb)
		else $error("receive strobe while transmitting");
	AST_STB_PULSE: assert property (rx_bit_stb |=> (!rx_bit_stb) [*8])
		else $error("receive strobe too wide");
	AST_RXBIT_HOLD: assert property ($changed(rx_bit) |-> rx_bit_stb)
		else $error("receive bit moved without strobe");
endmodule : rmbc_link_properties

// [tb/radio_modem_baseband_coder_test.sv]
/*
 * self-checking bench: host and modem ends joined by the link interface.
 * assumes the bench plays the processor side and the sliced receive line.
 */
`timescale 1ns/1ps

module radio_modem_baseband_coder_test;
	import rmbc_pkg::*;

	logic core_clk_i, resetn_i, tx_en_i, tx_byte_valid_i, rx_baseband_in_i, pend, s, lv, coll, u;
	logic [7:0] rb, rbx;
	int nb, nbv;
	logic [1:0] rate_sel_i;
	logic [7:0] tx_byte_i, rx_byte_o;
	logic tx_byte_ready_o, rx_byte_valid_o, tx_baseband_out_o, lvl, d;
	logic [1:0] filter_cutoff_o;
	logic filter_tx_path_o, filter_rx_path_o;
	logic [6:0] sr, rs;
	logic [31:0] rnd;
	logic txq[$];
	logic rxq[$];
	int err_count, checks, n;

	rmbc_link_if rmbc_link_if_inst ();
	// one clock feeds both ends
	rmbc_host_end rmbc_host_end_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.link(rmbc_link_if_inst.host), .rate_sel_i(rate_sel_i), .tx_en_i(tx_en_i),
		.tx_byte_i(tx_byte_i), .tx_byte_valid_i(tx_byte_valid_i),
		.tx_byte_ready_o(tx_byte_ready_o), .rx_byte_o(rx_byte_o),
		.rx_byte_valid_o(rx_byte_valid_o));
	rmbc_modem_end rmbc_modem_end_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.link(rmbc_link_if_inst.modem), .rx_baseband_in_i(rx_baseband_in_i),
		.tx_baseband_out_o(tx_baseband_out_o), .filter_cutoff_o(filter_cutoff_o),
		.filter_tx_path_o(filter_tx_path_o), .filter_rx_path_o(filter_rx_path_o));
	rmbc_link_properties rmbc_link_properties_inst (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .rate_sel(rmbc_link_if_inst.rate_sel),
		.tx_en(rmbc_link_if_inst.tx_en), .tx_bit_req(rmbc_link_if_inst.tx_bit_req),
		.rx_bit(rmbc_link_if_inst.rx_bit), .rx_bit_stb(rmbc_link_if_inst.rx_bit_stb),
		.tx_baseband_out_o(tx_baseband_out_o), .filter_cutoff_o(filter_cutoff_o),
		.filter_tx_path_o(filter_tx_path_o), .filter_rx_path_o(filter_rx_path_o));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction : xs

	// bit period in clocks; divisor rounds down, spare code runs fastest
	function automatic int per(input int r);
		int b;
		b = (r == 0) ? 4800 : (r == 1) ? 9600 : 19200;
		return 16 * (20000000 / (16 * b));
	endfunction : per

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// cycles up to the next bit request
	task automatic wait_req(output int c);
		c = 0;
		do begin
			@(posedge core_clk_i);
			c++;
		end while (rmbc_link_if_inst.tx_bit_req !== 1'b1);
	endtask : wait_req

	task automatic summarize();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// ----------------------------------------
	// transmit model: scrambler, nrzi and byte bit order; receive byte packing check
	// ----------------------------------------
	// line level is checked one edge after its request, once it has landed
	always @(posedge core_clk_i) begin
		if (!resetn_i) begin
			sr = 7'h00;
			lvl = 1'b0;
			pend = 1'b0;
			rb = 8'h00;
			rbx = 8'h00;
			nb = 0;
			nbv = 0;
		end else begin
			// a byte pulse shows the packing made one edge earlier, lsb first
			if (rx_byte_valid_o) chk(rx_byte_o, rbx);
			nbv += rx_byte_valid_o;
			if (rmbc_link_if_inst.rx_bit_stb) begin
				rb = {rmbc_link_if_inst.rx_bit, rb[7:1]};
				nb++;
				if (nb % 8 == 0) rbx = rb;
			end
			if (pend) chk(tx_baseband_out_o, lvl);
			pend = rmbc_link_if_inst.tx_bit_req;
			if (rmbc_link_if_inst.tx_bit_req) begin
				s = rmbc_link_if_inst.tx_bit ^ sr[6] ^ sr[3];
				sr = {sr[5:0], s};
				if (!s) lvl = ~lvl;
				if (!tx_byte_ready_o) chk(rmbc_link_if_inst.tx_bit, txq.pop_front());
			end
			if (tx_byte_valid_i && tx_byte_ready_o) begin
				for (int i = 0; i < 8; i++) txq.push_back(tx_byte_i[i]);
			end
			if (rmbc_link_if_inst.rx_bit_stb && coll) rxq.push_back(rmbc_link_if_inst.rx_bit);
		end
	end

	// ----------------------------------------
	// clock, reset, watchdog, scenarios
	// ----------------------------------------
	// stands in for the host's divided crystal clock, shared by both ends
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end

	initial begin
		#5000000;
		err_count++;
		summarize();
	end

	initial begin
		resetn_i = 1'b0;
		rate_sel_i = 2'h0;
		tx_en_i = 1'b0;
		tx_byte_i = 8'h00;
		tx_byte_valid_i = 1'b0;
		rx_baseband_in_i = 1'b0;
		coll = 1'b0;
		rnd = 32'haf47;
		rs = 7'h00;
		lv = 1'b0;
		repeat (4) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		tx_en_i <= 1'b1;
		// every rate code; the first cell after a change is mixed, the second is measured
		for (int r = 0; r < 4; r++) begin
			rate_sel_i <= r[1:0];
			wait_req(n);
			wait_req(n);
			chk(n, per(r));
			chk(filter_cutoff_o, r);
			chk(filter_tx_path_o, 1);
		end
		rate_sel_i <= 2'h2;
		wait_req(n);
		// three bytes back to back, offer held until taken
		repeat (3) begin
			rnd = xs(rnd);
			tx_byte_i <= rnd[7:0];
			tx_byte_valid_i <= 1'b1;
			do @(posedge core_clk_i); while (tx_byte_ready_o !== 1'b1);
		end
		tx_byte_valid_i <= 1'b0;
		do @(posedge core_clk_i); while (tx_byte_ready_o !== 1'b1);
		chk(txq.size(), 0);
		// receive: preamble of ones lets the descrambler fall into step
		tx_en_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		chk(filter_rx_path_o, 1);
		rnd = xs(rnd);
		coll = 1'b1;
		for (int k = 0; k < 34; k++) begin
			d = (k < 10) ? 1'b1 : rnd[k - 10];
			u = d ^ rs[6] ^ rs[3];
			rs = {rs[5:0], u};
			if (!u) lv = ~lv;
			rx_baseband_in_i <= lv;
			repeat (1040) @(posedge core_clk_i);
		end
		repeat (300) @(posedge core_clk_i);
		coll = 1'b0;
		chk(rxq.size() >= 24, 1);
		for (int i = 0; i < 24; i++) chk(rxq[rxq.size() - 24 + i], rnd[i]);
		chk(nbv, nb / 8);
		chk(nbv >= 4, 1);
		summarize();
	end
endmodule : radio_modem_baseband_coder_test
